// ### bench/serial_in_parallel_sink_driver_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module serial_in_parallel_sink_driver_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, clr_n = 1'b1, en_n = 1'b0;
  logic sclk, lclk, din, dout;
  logic [7:0] sink, sink_oe_n, b, st = 8'h00;
  int n_mismatch = 0, check_count = 0;
  integer seed = 32'h3698;
  always #25 clk = ~clk;
  sps_host host (.i_clk_sys(clk), .o_shift_clock(sclk),
    .o_latch_clock(lclk), .o_chain_input(din));
  sps_sink_driver dut (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_shift_clock(sclk), .i_latch_clock(lclk), .i_shift_clear_n(clr_n),
    .i_output_enable_n(en_n), .i_chain_input(din), .o_chain_output(dout),
    .o_sink_out(sink), .o_sink_oe_n(sink_oe_n));
  // sink on means enable low, so blanking reads all ones
  function automatic logic [7:0] exp_oe(logic [7:0] s, logic e);
    return e ? 8'hff : ~s;
  endfunction
  task automatic cmp(string nm, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmp_bit(string nm, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cmp("reset", 8'hff, sink_oe_n);
    for (int i = 0; i < 24; i++) begin
      b = (i < 2) ? {i[0], 7'h01} : 8'($random(seed));
      @(posedge clk);
      clr_n <= (i % 4 != 3);
      host.send(b);
      @(negedge clk);
      cmp_bit("chain", clr_n ? b[7] : 1'b0, dout);
      cmp("early", exp_oe(st, en_n), sink_oe_n);
      @(posedge clk);
      clr_n <= 1'b1;
      host.latch();
      st = (i % 4 != 3) ? b : 8'h00;
      @(negedge clk);
      cmp("sink_oe", exp_oe(st, en_n), sink_oe_n);
      cmp("drive", 8'h00, sink);
      @(posedge clk);
      en_n <= 1'($random(seed));
      @(negedge clk);
      cmp("blank", exp_oe(st, en_n), sink_oe_n);
    end
    // mid-run reset must empty both stages at once
    host.send(8'hc3);
    host.latch();
    @(posedge clk);
    rst_n <= 1'b0;
    en_n <= 1'b0;
    @(negedge clk);
    cmp("rst_oe", 8'hff, sink_oe_n);
    cmp_bit("rst_chain", 1'b0, dout);
    @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cmp("rst_drive", 8'h00, sink);
    results();
  end
endmodule
`default_nettype wire

// ### bench/sps_host.sv
`timescale 1ns/1ns
`default_nettype none
// host side: strobes one cycle high, one low, then the next bit
module sps_host (
  // clock
  input wire logic i_clk_sys,
  // serial controls to the device
  output logic o_shift_clock,
  output logic o_latch_clock,
  output logic o_chain_input
);
  initial begin
    o_shift_clock = 1'b0;
    o_latch_clock = 1'b0;
    o_chain_input = 1'b0;
  end
  // msb first; data flips in the low phase to expose late sampling
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_clk_sys);
      o_shift_clock <= 1'b1;
      o_chain_input <= b[i];
      @(posedge i_clk_sys);
      o_shift_clock <= 1'b0;
      o_chain_input <= ~b[i];
    end
  endtask
  // one latch pulse only after the whole byte is in
  task automatic latch();
    @(posedge i_clk_sys);
    o_latch_clock <= 1'b1;
    @(posedge i_clk_sys);
    o_latch_clock <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### rtl/sps_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
// rising-edge finder for a host strobe already synchronous to the clock
module sps_edge_detect (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // strobe in, one-cycle pulse out
  input wire logic i_level,
  output logic o_rise
);
  logic prev;
  logic next_prev;

  // remember last level so a held-high clock makes only one pulse
  always_comb begin
    next_prev = i_level;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end

  assign o_rise = i_level & ~prev;
endmodule
`default_nettype wire

// ### rtl/sps_pkg.sv
package sps_pkg;
  // width of one device's shift path
  localparam int STAGE_COUNT = 8;
  // value of the shift stages after reset or clear, and of storage after reset
  localparam logic [7:0] CLEAR_VALUE = 8'h00;
  // pulse spacing for host clocks on this one-clock fabric
  localparam int MIN_PULSE_NS = 40;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MIN_PULSE_CYC =
    (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### rtl/sps_sink_driver.sv
// Contract
// R01 - eight shift stages feed eight storage bits
// R02 - shift on shift clock, capture on latch
// R03 - clear low holds shift stages zero
// R04 - storage passes toward outputs when clear high
// R05 - enable high forces all outputs off
// R06 - enable low: outputs follow storage directly
// R07 - bit one sinks current, zero is off
// R08 - shift data presented on chain output
// R09 - chain output is last shift stage
// R10 - host shifts all, then latches once
`timescale 1ns/1ns
`default_nettype none
module sps_sink_driver
  import sps_pkg::*;
#(
  parameter int WIDTH = STAGE_COUNT
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // host serial controls, synchronous to i_clk_sys
  input wire logic i_shift_clock,
  input wire logic i_latch_clock,
  input wire logic i_shift_clear_n,
  input wire logic i_output_enable_n,
  input wire logic i_chain_input,
  // chain and open-drain sinks (oe low means pulling low)
  output logic o_chain_output,
  output logic [WIDTH-1:0] o_sink_out,
  output logic [WIDTH-1:0] o_sink_oe_n
);
  logic shift_rise;
  logic latch_rise;
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] next_shift_reg;
  logic [WIDTH-1:0] store_reg;
  logic [WIDTH-1:0] next_store_reg;
  logic [WIDTH-1:0] buf_bits;
  // shift edges seen since the last clear, read only by the checks
  localparam int CNT_W = $clog2(WIDTH + 1);
  logic [CNT_W-1:0] shift_count;
  logic [CNT_W-1:0] next_shift_count;

  // the host clocks are sampled, so edges become one-cycle pulses
  sps_edge_detect u_shift_edge (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_level(i_shift_clock),
    .o_rise(shift_rise)
  );

  sps_edge_detect u_latch_edge (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_level(i_latch_clock),
    .o_rise(latch_rise)
  );

  // a host clock held high for many cycles must still count once
  a_shift_single: assert property ( // R02
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    shift_rise |=> !shift_rise)
    else $error("shift edge seen twice");

  a_latch_single: assert property ( // R02
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    latch_rise |=> !latch_rise)
    else $error("latch edge seen twice");

  // shift stage: clear dominates any shift edge
  always_comb begin
    next_shift_reg = shift_reg;
    if (!i_shift_clear_n) begin
      next_shift_reg = WIDTH'(CLEAR_VALUE); // R03
    end else if (shift_rise) begin
      next_shift_reg = {shift_reg[WIDTH-2:0], i_chain_input}; // R02 R01
    end
  end

  // storage takes the shift stage as it stood before this edge
  always_comb begin
    next_store_reg = store_reg;
    if (latch_rise) begin
      next_store_reg = shift_reg; // R02 R01
    end
  end

  // shift stage register; reset loads constants only
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_reg <= WIDTH'(CLEAR_VALUE);
    end else begin
      shift_reg <= next_shift_reg;
    end
  end

  // count shift edges since clear, saturating at one full device
  always_comb begin
    next_shift_count = shift_count;
    if (!i_shift_clear_n) begin
      next_shift_count = '0;
    end else if (shift_rise && (shift_count < CNT_W'(WIDTH))) begin
      next_shift_count = shift_count + 1'b1;
    end
  end

  // reset agrees with the cleared shift stage, so the count starts at zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_count <= '0;
    end else begin
      shift_count <= next_shift_count;
    end
  end

  // storage kept in its own process so the shift clear never reaches it
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      store_reg <= WIDTH'(CLEAR_VALUE);
    end else begin
      store_reg <= next_store_reg;
    end
  end

  // clearing the shift stage must leave the shown pattern alone
  a_clear_store: assert property ( // R04
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (!i_shift_clear_n && !latch_rise) |=> $stable(store_reg))
    else $error("clear reached storage");

  // one gate per sink: clear touches only the shift stage, so storage
  // still reaches the buffers; enable high blanks every channel
  for (genvar g = 0; g < WIDTH; g++) begin : g_sink
    assign buf_bits[g] = store_reg[g] & ~i_output_enable_n; // R04 R05 R06
    // a buffered one turns the sink on; the pin only ever pulls low
    assign o_sink_oe_n[g] = ~buf_bits[g]; // R07
  end
  // pin level is always low; only the enable switches the sink
  assign o_sink_out = '0; // R07

  // end to end: a latch edge shows up on the sinks one cycle later
  a_latch_view: assert property ( // R06
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (latch_rise ##1 !i_output_enable_n) |->
    o_sink_oe_n == ~$past(shift_reg))
    else $error("latched data not on sinks");

  // an open-drain pin must never be driven high
  a_sink_level: assert property ( // R07
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_sink_out == '0)
    else $error("sink pin driven high");

  // last stage feeds the next device in the chain
  assign o_chain_output = shift_reg[WIDTH-1]; // R08 R09

  // a cleared device must pass zeros down the chain
  a_clear_chain: assert property ( // R08
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_shift_clear_n |=> !o_chain_output)
    else $error("chain output not cleared");

  // the next device samples on its own edges, so no glitch in between
  a_chain_hold: assert property ( // R08
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (!shift_rise && i_shift_clear_n) |=> $stable(o_chain_output))
    else $error("chain output moved without edge");

  // fewer than eight edges after clear: only cleared bits reach the end
  a_chain_empty: assert property ( // R09
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (shift_count < CNT_W'(WIDTH)) |-> !o_chain_output)
    else $error("chain output ahead of eight shifts");

  a_clear_zero: assert property ( // R03
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_shift_clear_n |=> shift_reg == '0)
    else $error("shift stage not cleared");

  a_shift_step: assert property ( // R02
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (shift_rise && i_shift_clear_n) |=>
    shift_reg == {$past(shift_reg[WIDTH-2:0]), $past(i_chain_input)})
    else $error("shift step wrong");

  a_shift_hold: assert property ( // R01
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (!shift_rise && i_shift_clear_n) |=> $stable(shift_reg))
    else $error("shift stage moved without edge");

  a_latch_take: assert property ( // R02
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    latch_rise |=> store_reg == $past(shift_reg))
    else $error("storage missed capture");

  a_store_hold: assert property ( // R04
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !latch_rise |=> $stable(store_reg))
    else $error("storage changed without latch");

  a_blank_off: assert property ( // R05
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_output_enable_n |-> o_sink_oe_n == '1)
    else $error("sink on while blanked");

  a_enable_pass: assert property ( // R06
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_output_enable_n |-> o_sink_oe_n == ~store_reg)
    else $error("outputs not following storage");

  a_chain_delay: assert property ( // R09
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (shift_rise && i_shift_clear_n) |=> o_chain_output ==
    $past(shift_reg[WIDTH-2]))
    else $error("chain output not last stage");
endmodule
`default_nettype wire
